// ===== hw/hsgf_top.sv
`timescale 1ns/10ps
module hsgf_top
  import hsgf_pkg::*;
#(
  parameter int DEB_CYCLES    = DEB_CYC,
  parameter int FETBAD_CYCLES = FETBAD_CYC,
  parameter int WDOG_CYCLES   = WDOG_CYC
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // comparator and pin levels, asynchronous
  input  wire logic              turn_on_req_b,
  input  wire logic              gate_supply_ok,
  input  wire logic              internal_supply_ok,
  input  wire logic              uv_high_above,
  input  wire logic              uv_low_above,
  input  wire logic              uv_low_reset,
  input  wire logic              overvoltage_input,
  input  wire logic              drain_low,
  input  wire logic              drain_bad,
  input  wire logic              gate_enhanced,
  input  wire logic              output_low_trip,
  input  wire logic              output_short,
  input  wire logic              current_limit,
  input  wire logic              soa_timer_trip,
  // straps
  input  wire logic [1:0]        mode_strap,
  input  wire logic [1:0]        address_strap_a,
  input  wire logic [1:0]        address_strap_b,
  // configuration
  input  wire logic [FLT_W-1:0]  fault_alert_en,
  input  wire logic [7:0]        meas_alert,
  input  wire logic [7:0]        meas_alert_en,
  input  wire logic [2:0]        pg1_cfg,
  input  wire logic [2:0]        pg2_cfg,
  input  wire logic [1:0]        pg3_cfg,
  input  wire logic [1:0]        pg4_cfg,
  input  wire logic [3:0]        pgio_gpo,
  input  wire logic [3:0]        adio_od_en,
  input  wire logic [3:0]        adio_gpo,
  // register port
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // gate drive
  output logic                   primary_gate_drive,
  output logic                   secondary_gate_drive,
  output logic                   fast_pulldown,
  output logic                   soa_timer_enable,
  // status
  output logic                   power_good,
  output logic                   output_low_status,
  output logic      [FLT_W-1:0]  fault_status,
  output logic                   turn_on_event,
  output hsgf_mode_t             mode,
  output logic      [6:0]        bus_address,
  output logic                   broadcast_mode,
  // open-drain and general pins
  output logic                   alert_oe,
  input  wire logic [3:0]        pgio_i,
  output logic      [3:0]        pgio_o,
  output logic      [3:0]        pgio_oe,
  output logic      [3:0]        pgio_gpi,
  input  wire logic [3:0]        adio_i,
  output logic      [3:0]        adio_o,
  output logic      [3:0]        adio_oe,
  output logic      [3:0]        adio_gpi
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int SW = 28;

  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  logic req_s, en_s, vin_s, icc_s, uvh_s, uvl_s, uvr_s, ov_s, dlow_s, dbad_s, genh_s;
  logic olow_s, short_s, cl_s, tmr_s;
  logic [1:0] mode_s, adra_s, adrb_s;
  logic [3:0] pgio_s, adio_s;

  // request enters inverted so the synchroniser's reset value is the idle level: no false edge after reset
  assign raw = {~turn_on_req_b, gate_supply_ok, internal_supply_ok, uv_high_above, uv_low_above,
                uv_low_reset, overvoltage_input, drain_low, drain_bad, gate_enhanced,
                output_low_trip, output_short, current_limit, soa_timer_trip,
                mode_strap, address_strap_a, address_strap_b, pgio_i, adio_i};
  assign {req_s, vin_s, icc_s, uvh_s, uvl_s, uvr_s, ov_s, dlow_s, dbad_s, genh_s,
          olow_s, short_s, cl_s, tmr_s, mode_s, adra_s, adrb_s, pgio_s, adio_s} = syn;
  assign en_s = ~req_s;

  hsgf_sync #(.W(SW)) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     (raw),
    .q     (syn)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] strap_level(input logic [1:0] lvl);
    case (lvl)
      LVL_LOW:  strap_level = 4'h0;
      LVL_HIGH: strap_level = 4'h2;
      default:  strap_level = 4'h1;
    endcase
  endfunction

  // open-drain enable for pins one and two; high means pulling low
  function automatic logic pg_pin_oe(input logic [2:0] cfg, input logic pg, input logic pg_seq,
                                     input logic gpo);
    case (cfg)
      PG12_SEQ:    pg_pin_oe = ~pg_seq;
      PG12_INV:    pg_pin_oe = pg;
      PG12_NONINV: pg_pin_oe = ~pg;
      PG12_OD:     pg_pin_oe = ~gpo;
      default:     pg_pin_oe = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]       ctrl_reg, ctrl_next, rdata_next;
  logic [CNT_W-1:0] deb_cnt_reg, deb_cnt_next, fb_cnt_reg, fb_cnt_next, wd_cnt_reg, wd_cnt_next;
  logic             deb_done_reg, deb_done_next;
  logic [FLT_W-1:0] fault_reg, fault_next, fault_set;
  logic             pri_next, sec_next, fpd_next, tmr_next, pg_next, pgd_reg, pgd_next;
  logic             en_d_reg, evt_next, alert_next;
  logic [1:0]       strap_cnt_reg;
  logic [3:0]       pgio_oe_next;
  logic             uv_ok, allow, en_fall, fault_clr, ovl, wd_active, ext_active, mode4_hold;
  hsgf_mode_t       mode_next;
  logic [3:0]       adr_idx;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (reg_wr && reg_addr == CTRL1_OFFSET) begin
      ctrl_next = reg_wdata;
    end
    rdata_next = (reg_addr == CTRL1_OFFSET) ? ctrl_reg : 8'h00;

    uv_ok     = uvh_s & uvl_s;
    en_fall   = en_d_reg & ~en_s;
    fault_clr = en_fall | uvr_s;
    ovl       = cl_s;
    wd_active = (pg3_cfg == PG34_ACT_LO) ? ~pgio_s[2] : pgio_s[2];
    ext_active = (pg4_cfg == PG34_ACT_LO) ? ~pgio_s[3] :
                 (pg4_cfg == PG34_ACT_HI) ?  pgio_s[3] : 1'b0;

    // debounce runs only while the request is held low
    deb_cnt_next  = '0;
    deb_done_next = 1'b0;
    if (!en_s) begin
      deb_done_next = deb_done_reg | (deb_cnt_reg == CNT_W'(DEB_CYCLES - 1));
      deb_cnt_next  = deb_done_next ? deb_cnt_reg : deb_cnt_reg + 1'b1;
    end

    // FET-bad timer restarts each time the drain drops back
    fb_cnt_next = dbad_s ? ((fb_cnt_reg == CNT_W'(FETBAD_CYCLES)) ? fb_cnt_reg
                                                                   : fb_cnt_reg + 1'b1) : '0;
    wd_cnt_next = (power_good && !wd_active && pg3_cfg <= PG34_ACT_HI) ?
                  ((wd_cnt_reg == CNT_W'(WDOG_CYCLES)) ? wd_cnt_reg : wd_cnt_reg + 1'b1) : '0;

    fault_set             = '0;
    fault_set[FLT_OV]     = ov_s;
    fault_set[FLT_OC]     = tmr_s;
    fault_set[FLT_FETBAD] = fb_cnt_reg == CNT_W'(FETBAD_CYCLES);
    fault_set[FLT_EXT]    = ext_active;
    fault_set[FLT_WDOG]   = wd_cnt_reg == CNT_W'(WDOG_CYCLES);
    fault_set[FLT_SHORT]  = short_s;
    // a new event beats the clear in the same cycle
    fault_next = (fault_clr ? '0 : fault_reg) | fault_set;

    allow = ~en_s & vin_s & icc_s & uv_ok & ~ov_s & (fault_reg == '0) & deb_done_reg;
    pri_next   = allow;
    mode4_hold = secondary_gate_drive & (mode == MODE_STAGED_LO);
    case (mode)
      MODE_SINGLE:    sec_next = allow;
      MODE_PARALLEL:  sec_next = allow;
      MODE_STAGED_HI: sec_next = allow & primary_gate_drive & genh_s & dlow_s & ~ovl;
      MODE_STAGED_LO: sec_next = allow & (mode4_hold | (primary_gate_drive & genh_s & dlow_s));
      default:        sec_next = 1'b0;
    endcase

    fpd_next = short_s;
    tmr_next = dbad_s & ~cl_s;
    // overvoltage freezes the power good state
    pg_next  = fault_reg[FLT_OV] ? power_good
             : (primary_gate_drive & dlow_s & genh_s & ~olow_s);
    pgd_next = pg_next & power_good;
    evt_next = en_s ^ en_d_reg;
    alert_next = |(fault_reg & fault_alert_en) | |(meas_alert & meas_alert_en);

    pgio_oe_next[0] = pg_pin_oe(pg1_cfg, power_good, power_good, pgio_gpo[0]);
    pgio_oe_next[1] = (ctrl_reg[CTRL1_CL_FLAG] && power_good) ? cl_s
                    : pg_pin_oe(pg2_cfg, power_good, pgd_reg, pgio_gpo[1]);
    pgio_oe_next[2] = (pg3_cfg == PG34_OD) & ~pgio_gpo[2];
    pgio_oe_next[3] = (pg4_cfg == PG34_OD) & ~pgio_gpo[3];

    case (mode_s)
      MSTRAP_OPEN: mode_next = MODE_SINGLE;
      MSTRAP_GND:  mode_next = MODE_PARALLEL;
      MSTRAP_GSUP: mode_next = MODE_STAGED_HI;
      MSTRAP_ISUP: mode_next = MODE_STAGED_LO;
      default:     mode_next = MODE_SINGLE;
    endcase
    adr_idx = 4'(strap_level(adra_s) * 4'h3) + strap_level(adrb_s);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_reg             <= CTRL1_RESET;
      reg_rdata            <= 8'h00;
      deb_cnt_reg          <= '0;
      deb_done_reg         <= 1'b0;
      fb_cnt_reg           <= '0;
      wd_cnt_reg           <= '0;
      fault_reg            <= '0;
      primary_gate_drive   <= 1'b0;
      secondary_gate_drive <= 1'b0;
      fast_pulldown        <= 1'b0;
      soa_timer_enable     <= 1'b0;
      power_good           <= 1'b0;
      pgd_reg              <= 1'b0;
      output_low_status    <= 1'b0;
      fault_status         <= '0;
      en_d_reg             <= 1'b1;
      turn_on_event        <= 1'b0;
      alert_oe             <= 1'b0;
      pgio_o               <= 4'h0;
      pgio_oe              <= 4'h0;
      pgio_gpi             <= 4'h0;
      adio_o               <= 4'h0;
      adio_oe              <= 4'h0;
      adio_gpi             <= 4'h0;
      strap_cnt_reg        <= 2'h0;
      mode                 <= MODE_SINGLE;
      bus_address          <= ADDR_BASE;
      broadcast_mode       <= 1'b0;
    end else begin
      ctrl_reg             <= ctrl_next;
      reg_rdata            <= rdata_next;
      deb_cnt_reg          <= deb_cnt_next;
      deb_done_reg         <= deb_done_next;
      fb_cnt_reg           <= fb_cnt_next;
      wd_cnt_reg           <= wd_cnt_next;
      fault_reg            <= fault_next;
      primary_gate_drive   <= pri_next;
      secondary_gate_drive <= sec_next;
      fast_pulldown        <= fpd_next;
      soa_timer_enable     <= tmr_next;
      power_good           <= pg_next;
      pgd_reg              <= pgd_next;
      output_low_status    <= olow_s;
      fault_status         <= fault_next;
      en_d_reg             <= en_s;
      turn_on_event        <= evt_next;
      alert_oe             <= alert_next;
      pgio_o               <= 4'h0;
      pgio_oe              <= pgio_oe_next;
      pgio_gpi             <= pgio_s;
      adio_o               <= 4'h0;
      adio_oe              <= adio_od_en & ~adio_gpo;
      adio_gpi             <= adio_s;
      // straps sampled once, third edge after release; earlier the synchroniser still shows its reset zeros
      if (strap_cnt_reg != 2'h3) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_cnt_reg == 2'h2) begin
        mode           <= mode_next;
        bus_address    <= ADDR_BASE + {3'h0, adr_idx};
        broadcast_mode <= adr_idx == BCAST_IDX;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_gate_off_req:  assert property (en_s |=> !primary_gate_drive && !secondary_gate_drive)
    else $error("gates on while request high");
  a_gate_debounce: assert property ($rose(primary_gate_drive) |-> $past(deb_done_reg))
    else $error("gate on before debounce");
  a_ov_gates_off:  assert property (ov_s |=> !primary_gate_drive ##0 fault_reg[FLT_OV])
    else $error("overvoltage did not stop gates");
  a_fault_clear:   assert property (en_fall && fault_set == '0 |=> fault_reg == '0)
    else $error("faults not cleared by request edge");
  a_short_pd:      assert property (short_s |=> fast_pulldown)
    else $error("fast pull-down missing");
  a_parallel_eq:   assert property (mode == MODE_PARALLEL |-> primary_gate_drive == secondary_gate_drive)
    else $error("parallel gates differ");
  a_staged_ovl:    assert property (mode == MODE_STAGED_HI && cl_s |=> !secondary_gate_drive)
    else $error("secondary on under overload");
  a_pg_ov_hold:    assert property (fault_reg[FLT_OV] |=> $stable(power_good))
    else $error("power good moved under ov fault");
  a_alert_fault:   assert property ((fault_reg & fault_alert_en) != '0 |=> alert_oe)
    else $error("alert not asserted");
  a_cl_flag:       assert property (ctrl_reg[CTRL1_CL_FLAG] && power_good && cl_s |=> pgio_oe[1])
    else $error("current limit flag missing");

  c_staged_on:  cover property (mode == MODE_STAGED_HI && $rose(secondary_gate_drive));
  c_req_fall:   cover property (en_fall ##1 fault_reg == '0);
  c_ov_fault:   cover property ($rose(fault_reg[FLT_OV]));
  c_alert:      cover property ($rose(alert_oe));

endmodule

// ===== hw/hsgf_pkg.sv
package hsgf_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS     = 25;
  localparam int DEBOUNCE_TIME_US  = 50;
  localparam int FETBAD_TIME_US    = 1000;
  localparam int WDOG_TIME_US      = 10000;
  localparam int DEB_CYC           = (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FETBAD_CYC        = (FETBAD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDOG_CYC          = (WDOG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 20;

  // register map
  localparam logic [7:0] CTRL1_OFFSET   = 8'h0A;
  localparam logic [7:0] CTRL1_RESET    = 8'h00;
  localparam int         CTRL1_CL_FLAG  = 0;

  // fault vector bit positions
  localparam int FLT_W       = 6;
  localparam int FLT_OV      = 0;
  localparam int FLT_OC      = 1;
  localparam int FLT_FETBAD  = 2;
  localparam int FLT_EXT     = 3;
  localparam int FLT_WDOG    = 4;
  localparam int FLT_SHORT   = 5;

  // three-level strap codes from the strap comparators
  localparam logic [1:0] LVL_LOW   = 2'h0;
  localparam logic [1:0] LVL_OPEN  = 2'h1;
  localparam logic [1:0] LVL_HIGH  = 2'h2;

  // mode strap codes
  localparam logic [1:0] MSTRAP_OPEN   = 2'h0;
  localparam logic [1:0] MSTRAP_GND    = 2'h1;
  localparam logic [1:0] MSTRAP_GSUP   = 2'h2;
  localparam logic [1:0] MSTRAP_ISUP   = 2'h3;

  // bus address decode; base and broadcast slot are arbitrary
  localparam logic [6:0] ADDR_BASE   = 7'h40;
  localparam logic [3:0] BCAST_IDX   = 4'h8;

  // pin role codes
  localparam logic [2:0] PG12_SEQ    = 3'h0;
  localparam logic [2:0] PG12_INV    = 3'h1;
  localparam logic [2:0] PG12_NONINV = 3'h2;
  localparam logic [2:0] PG12_GPI    = 3'h3;
  localparam logic [2:0] PG12_OD     = 3'h4;
  localparam logic [1:0] PG34_ACT_LO = 2'h0;
  localparam logic [1:0] PG34_ACT_HI = 2'h1;
  localparam logic [1:0] PG34_GPI    = 2'h2;
  localparam logic [1:0] PG34_OD     = 2'h3;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_PARALLEL,
    MODE_STAGED_HI,
    MODE_STAGED_LO
  } hsgf_mode_t;

endpackage

// ===== hw/hsgf_sync.sv
`timescale 1ns/10ps
module hsgf_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ===== verification/hsgf_fet_model.sv
`timescale 1ns/10ps
module hsgf_fet_model #(
  parameter int RISE_CYC = 3
) (
  // clock
  input  wire logic clock,
  // gate drive from the controller
  input  wire logic gate_on,
  // comparator levels seen by the controller
  output logic      gate_enhanced,
  output logic      drain_low
);
  int unsigned ramp_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // gate charges over a few cycles, so enhanced never follows a rising drive at once
  always @(posedge clock) begin
    if (gate_on !== 1'b1) begin
      ramp_cnt <= 0;
    end else if (ramp_cnt < RISE_CYC) begin
      ramp_cnt <= ramp_cnt + 1;
    end
  end

  // drain only falls once the channel is fully on
  assign gate_enhanced = (gate_on === 1'b1) && (ramp_cnt >= RISE_CYC);
  assign drain_low     = gate_enhanced;
endmodule

// ===== verification/hot_swap_gate_fault_control_test.sv
`timescale 1ns/10ps
module hot_swap_gate_fault_control_test;
  import hsgf_pkg::*;
  localparam int DEB = 4;
  logic clock = 1'b0, rst_b = 1'b0, turn_on_req_b = 1'b1, gate_supply_ok = 1'b1, internal_supply_ok = 1'b1;
  logic uv_high_above = 1'b1, uv_low_above = 1'b1, uv_low_reset = 1'b0, overvoltage_input = 1'b0;
  logic drain_bad = 1'b0, output_low_trip = 1'b0, output_short = 1'b0, current_limit = 1'b0;
  logic soa_timer_trip = 1'b0, reg_wr = 1'b0, gate_enhanced, drain_low;
  logic [1:0] mode_strap = 2'h0, address_strap_a = 2'h0, address_strap_b = 2'h0;
  logic [FLT_W-1:0] fault_alert_en = '1;
  logic [7:0] meas_alert = 8'h00, meas_alert_en = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0] pg1_cfg = PG12_NONINV, pg2_cfg = PG12_INV;
  logic [1:0] pg3_cfg = PG34_GPI, pg4_cfg = PG34_GPI;
  logic [3:0] pgio_gpo = 4'hF, adio_od_en = 4'h0, adio_gpo = 4'hF;
  logic primary_gate_drive, secondary_gate_drive, fast_pulldown, soa_timer_enable, power_good;
  logic output_low_status, turn_on_event, broadcast_mode, alert_oe;
  logic [FLT_W-1:0] fault_status;
  hsgf_mode_t mode;
  logic [6:0] bus_address;
  logic [3:0] pgio_i, pgio_o, pgio_oe, pgio_gpi, adio_i, adio_o, adio_oe, adio_gpi;
  int n_errors = 0, n_compared = 0, n_events = 0;

  // pulled-up open-drain pins
  assign pgio_i = ~pgio_oe;
  assign adio_i = ~adio_oe;
  always #12.5 clock = ~clock;
  always @(posedge clock) if (turn_on_event === 1'b1) n_events++;

  hsgf_top #(.DEB_CYCLES(DEB), .FETBAD_CYCLES(8), .WDOG_CYCLES(8)) u_hsgf_top (
    .clock(clock), .rst_b(rst_b), .turn_on_req_b(turn_on_req_b), .gate_supply_ok(gate_supply_ok),
    .internal_supply_ok(internal_supply_ok), .uv_high_above(uv_high_above), .uv_low_above(uv_low_above),
    .uv_low_reset(uv_low_reset), .overvoltage_input(overvoltage_input), .drain_low(drain_low),
    .drain_bad(drain_bad), .gate_enhanced(gate_enhanced), .output_low_trip(output_low_trip),
    .output_short(output_short), .current_limit(current_limit), .soa_timer_trip(soa_timer_trip),
    .mode_strap(mode_strap), .address_strap_a(address_strap_a), .address_strap_b(address_strap_b),
    .fault_alert_en(fault_alert_en), .meas_alert(meas_alert), .meas_alert_en(meas_alert_en),
    .pg1_cfg(pg1_cfg), .pg2_cfg(pg2_cfg), .pg3_cfg(pg3_cfg), .pg4_cfg(pg4_cfg), .pgio_gpo(pgio_gpo),
    .adio_od_en(adio_od_en), .adio_gpo(adio_gpo), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .primary_gate_drive(primary_gate_drive),
    .secondary_gate_drive(secondary_gate_drive), .fast_pulldown(fast_pulldown),
    .soa_timer_enable(soa_timer_enable), .power_good(power_good), .output_low_status(output_low_status),
    .fault_status(fault_status), .turn_on_event(turn_on_event), .mode(mode), .bus_address(bus_address),
    .broadcast_mode(broadcast_mode), .alert_oe(alert_oe), .pgio_i(pgio_i), .pgio_o(pgio_o),
    .pgio_oe(pgio_oe), .pgio_gpi(pgio_gpi), .adio_i(adio_i), .adio_o(adio_o), .adio_oe(adio_oe),
    .adio_gpi(adio_gpi));
  hsgf_fet_model u_hsgf_fet_model (.clock(clock), .gate_on(primary_gate_drive), .gate_enhanced(gate_enhanced),
                                   .drain_low(drain_low));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // sel 0 waits on the primary gate, 1 on power good
  task automatic wait_for(input int sel, input logic want, output int cyc);
    logic seen;
    for (cyc = 0; cyc < 60; cyc++) begin
      seen = (sel == 0) ? primary_gate_drive : power_good;
      if (seen === want) return;
      tick(1);
    end
    check(seen, want, "bounded wait ran out");
    give_verdict();
  endtask
  task automatic do_reset(input logic [1:0] ms, input logic [1:0] a, input logic [1:0] b);
    rst_b = 1'b0;
    turn_on_req_b = 1'b1;
    mode_strap = ms;
    address_strap_a = a;
    address_strap_b = b;
    tick(10);
    rst_b = 1'b1;
    tick(3);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    tick(1);
    check(reg_rdata, exp, "register read");
  endtask
  task automatic start_up();
    int c;
    turn_on_req_b = 1'b1;
    tick(4);
    turn_on_req_b = 1'b0;
    wait_for(0, 1'b1, c);
    wait_for(1, 1'b1, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_straps();
    hsgf_mode_t exp_mode [4] = '{MODE_SINGLE, MODE_PARALLEL, MODE_STAGED_HI, MODE_STAGED_LO};
    for (int i = 0; i < 9; i++) begin
      do_reset(2'(i % 4), 2'(i / 3), 2'(i % 3));
      check(8'(mode), 8'(exp_mode[i % 4]), "mode decode");
      check(8'(bus_address), 8'(ADDR_BASE + 7'(i)), "bus address");
      check(8'(broadcast_mode), 8'(i == 8), "broadcast select");
    end
    check(8'(n_events), 8'h00, "no event from reset");
    reg_read(CTRL1_OFFSET, CTRL1_RESET);
    reg_write(8'h0B, 8'hFF);
    reg_read(8'h0B, 8'h00);
    reg_write(CTRL1_OFFSET, 8'h01);
    reg_read(CTRL1_OFFSET, 8'h01);
    reg_write(CTRL1_OFFSET, 8'h00);
  endtask
  task automatic t_startup();
    int c, e0;
    gate_supply_ok = 1'b0;
    turn_on_req_b = 1'b0;
    tick(DEB + 10);
    check(primary_gate_drive, 8'h00, "gate on under lockout");
    e0 = n_events;
    turn_on_req_b = 1'b1;
    gate_supply_ok = 1'b1;
    tick(4);
    turn_on_req_b = 1'b0;
    wait_for(0, 1'b1, c);
    check(8'(c >= DEB + 2 && c <= DEB + 5), 8'h01, "debounce length");
    check(8'(n_events - e0), 8'h02, "request edge events");
    check(secondary_gate_drive, 8'h01, "single mode secondary");
    check(8'(pgio_oe[1:0]), 8'h01, "pg pins before power good");
    wait_for(1, 1'b1, c);
    tick(2);
    check(8'(pgio_oe[1:0]), 8'h02, "pg pins after power good");
    output_low_trip = 1'b1;
    tick(4);
    check(8'({output_low_status, power_good}), 8'h02, "output low trip");
    output_low_trip = 1'b0;
    reg_write(CTRL1_OFFSET, 8'h01);
    current_limit = 1'b1;
    tick(4);
    check(pgio_oe[1], 8'h01, "current limit flag engaged");
    current_limit = 1'b0;
    tick(4);
    check(pgio_oe[1], 8'h00, "current limit flag idle");
    reg_write(CTRL1_OFFSET, 8'h00);
  endtask
  task automatic t_overvoltage();
    int c, e0;
    start_up();
    overvoltage_input = 1'b1;
    wait_for(0, 1'b0, c);
    tick(1);
    check(secondary_gate_drive, 8'h00, "secondary off on overvoltage");
    check(fault_status[FLT_OV], 8'h01, "overvoltage recorded");
    check(power_good, 8'h01, "power good frozen");
    check(alert_oe, 8'h01, "alert on fault");
    fault_alert_en = '0;
    tick(3);
    check(alert_oe, 8'h00, "alert masked");
    fault_alert_en = '1;
    overvoltage_input = 1'b0;
    tick(DEB + 8);
    check(primary_gate_drive, 8'h00, "fault stays latched");
    e0 = n_events;
    turn_on_req_b = 1'b1;
    tick(5);
    check(8'({primary_gate_drive, secondary_gate_drive}), 8'h00, "request high gates");
    turn_on_req_b = 1'b0;
    tick(5);
    check(8'(fault_status), 8'h00, "faults cleared by request");
    check(8'(n_events - e0), 8'h02, "edge events");
  endtask
  task automatic t_short_drain();
    start_up();
    drain_bad = 1'b1;
    tick(4);
    check(soa_timer_enable, 8'h01, "timer current on drain high");
    current_limit = 1'b1;
    tick(4);
    check(soa_timer_enable, 8'h00, "timer current in current limit");
    current_limit = 1'b0;
    tick(8);
    check(fault_status[FLT_FETBAD], 8'h01, "drain fault timer");
    drain_bad = 1'b0;
    start_up();
    output_short = 1'b1;
    tick(4);
    check(8'({fast_pulldown, primary_gate_drive}), 8'h02, "short pulldown");
    output_short = 1'b0;
    tick(4);
    check(fault_status[FLT_SHORT], 8'h01, "short latched");
    uv_low_reset = 1'b1;
    tick(4);
    uv_low_reset = 1'b0;
    tick(4);
    check(8'(fault_status), 8'h00, "undervoltage reset clears");
  endtask
  task automatic t_parallel();
    do_reset(MSTRAP_GND, 2'h0, 2'h0);
    start_up();
    check(8'({primary_gate_drive, secondary_gate_drive}), 8'h03, "parallel gates on");
    soa_timer_trip = 1'b1;
    tick(4);
    check(8'({primary_gate_drive, secondary_gate_drive}), 8'h00, "parallel gates off on overload");
    check(fault_status[FLT_OC], 8'h01, "overcurrent recorded");
    soa_timer_trip = 1'b0;
  endtask
  task automatic t_pins();
    start_up();
    adio_od_en = 4'h5;
    adio_gpo = 4'h4;
    pg3_cfg = PG34_ACT_LO;
    tick(4);
    check(8'(adio_oe), 8'h01, "analog pin drive");
    check(8'(adio_gpi), 8'h0E, "analog pin input");
    tick(12);
    check(fault_status[FLT_WDOG], 8'h01, "watchdog fault");
    pg3_cfg = PG34_OD;
    pgio_gpo = 4'hB;
    pg4_cfg = PG34_ACT_HI;
    tick(4);
    check(8'(pgio_oe[3:2]), 8'h01, "pin three drive");
    check(8'(pgio_gpi[3:2]), 8'h02, "pin three and four input");
    check(fault_status[FLT_EXT], 8'h01, "external fault");
    check(8'({pgio_o, adio_o}), 8'h00, "open-drain data low");
    fault_alert_en = '0;
    meas_alert = 8'h02;
    meas_alert_en = 8'h02;
    tick(2);
    check(alert_oe, 8'h01, "measurement alert");
    meas_alert_en = 8'h00;
    tick(2);
    check(alert_oe, 8'h00, "measurement alert masked");
  endtask
  task automatic t_staged();
    int c;
    for (int m = 0; m < 2; m++) begin
      do_reset(m == 0 ? MSTRAP_GSUP : MSTRAP_ISUP, 2'h0, 2'h0);
      start_up();
      turn_on_req_b = 1'b1;
      tick(4);
      turn_on_req_b = 1'b0;
      wait_for(0, 1'b1, c);
      check(secondary_gate_drive, 8'h00, "secondary waits for primary");
      wait_for(1, 1'b1, c);
      tick(2);
      check(secondary_gate_drive, 8'h01, "secondary after enhance");
      current_limit = 1'b1;
      tick(4);
      check(secondary_gate_drive, 8'(m), "secondary under overload");
      current_limit = 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_straps();
    t_startup();
    t_overvoltage();
    t_short_drain();
    t_parallel();
    t_staged();
    t_pins();
    give_verdict();
  end
endmodule
